//--- hdl/bps_pkg.sv
// Purpose: shared constants and types for the buck protection sequencer
// Assumes: one system clock; switching cycles arrive as one-cycle ticks
// Notes: flag indices give the order of the comparator input vector
package bps_pkg;

   typedef enum logic [1:0]
   {
      BPS_ST_OFF    = 2'b00,
      BPS_ST_DISCH  = 2'b01,
      BPS_ST_RUN    = 2'b10,
      BPS_ST_HICCUP = 2'b11
   } bps_state_t;

   // switching-cycle counts
   localparam int BPS_OVL_TICKS = 512;
   localparam int BPS_HICCUP_TICKS = 16384;
   // internal switching period in sys_clk cycles (500 kHz at 200 MHz)
   localparam int BPS_TICK_PERIOD = 400;
   localparam int BPS_SYNC_STAGES = 2;

   // comparator flag positions
   localparam int BPS_F_EN = 0;
   localparam int BPS_F_UVLOCK = 1;
   localparam int BPS_F_TTRIP = 2;
   localparam int BPS_F_TREL = 3;
   localparam int BPS_F_GDLOW = 4;
   localparam int BPS_F_GUARD = 5;
   localparam int BPS_F_PEAK = 6;
   localparam int BPS_F_LSSRC = 7;
   localparam int BPS_F_LSSINK = 8;
   localparam int BPS_F_OVL = 9;
   localparam int BPS_F_FBWIN = 10;
   localparam int BPS_F_FBOUT = 11;
   localparam int BPS_F_SSREF = 12;
   localparam int BPS_F_SS14 = 13;
   localparam int BPS_F_SSGND = 14;
   localparam int BPS_F_LSREV = 15;
   localparam int BPS_F_EXTCLK = 16;
   localparam int BPS_F_FSP = 17;
   localparam int BPS_FLAG_W = 18;

   // reset values of driven outputs
   localparam logic BPS_PG_PD_RST = 1'b1;
   localparam logic BPS_LOWP_RST = 1'b1;

endpackage

//--- hdl/bps_sync.sv
// Purpose: multi-stage synchroniser for a vector of async levels
// Assumes: each bit is an independent level, no bus coherence needed
// Notes: only the last stage is visible outside
`timescale 1ns/1ps
module bps_sync
   import bps_pkg::*;
#(
   parameter int WIDTH = BPS_FLAG_W,
   parameter int STAGES = BPS_SYNC_STAGES
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic [STAGES-1:0] chain_reg;
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               chain_reg <= '0;
            else
               chain_reg <= {chain_reg[STAGES-2:0], async_in[i]};
         end
         assign sync_out[i] = chain_reg[STAGES-1];
      end
   endgenerate

endmodule

//--- hdl/bps_sequencer.sv
// Purpose: supervisory and protection sequencer of a synchronous buck
// Assumes: comparator flags are asynchronous levels
// Notes: timing counts are in switching-cycle ticks, except the tick divider, which counts sys_clk cycles
// How it works
// RULE_01 - regulate to lower of soft start, reference
// RULE_02 - undervoltage, enable low, thermal stop switching
// RULE_03 - discharge soft start before any restart
// RULE_04 - release power good inside 94-104 percent
// RULE_05 - pull power good outside 92-106 percent
// RULE_06 - pull power good on fault or low ss
// RULE_07 - high side may stay on indefinitely
// RULE_08 - gate supply low: high off, low on
// RULE_09 - overshoot holds high side off
// RULE_10 - after overshoot wait for next cycle
// RULE_11 - peak current trip ends high-side pulse
// RULE_12 - sourcing limit at cycle end skips pulse
// RULE_13 - resume pulse once sourcing limit clears
// RULE_14 - sinking limit: both off until next cycle
// RULE_15 - overload over 512 cycles, hiccup 16384
// RULE_16 - over temperature stops switching
// RULE_17 - thermal release, 16384 cycle hiccup, restart
// RULE_18 - no low-side sinking below 1.4 V ss
// RULE_19 - external clock falling edge starts cycle
// RULE_20 - synchronise flags, count hiccups in ticks
`timescale 1ns/1ps
module bps_sequencer
   import bps_pkg::*;
#(
   parameter int HICCUP_TICKS = BPS_HICCUP_TICKS,
   parameter int OVL_TICKS = BPS_OVL_TICKS,
   parameter int TICK_PERIOD = BPS_TICK_PERIOD
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic en_above_thr,
   input wire logic undervoltage_lockout,
   input wire logic therm_trip,
   input wire logic therm_release,
   input wire logic gd_supply_low,
   input wire logic overshoot_guard,
   input wire logic peak_trip,
   input wire logic ls_source_limit,
   input wire logic ls_sink_limit,
   input wire logic overload,
   input wire logic fb_in_window,
   input wire logic fb_out_window,
   input wire logic ss_below_ref,
   input wire logic ss_above_1p4,
   input wire logic ss_at_ground,
   input wire logic ls_reverse,
   input wire logic ext_clk_mode,
   input wire logic frequency_set_pin,
   output logic hs_on,
   output logic ls_on,
   output logic power_good_out_o,
   output logic power_good_out_oe,
   output logic ss_discharge,
   output logic ref_from_ss,
   output logic low_power,
   output logic hiccup_active
);

   localparam int HW = $clog2(HICCUP_TICKS + 1);
   localparam int OW = $clog2(OVL_TICKS + 2);
   localparam int DW = $clog2(TICK_PERIOD + 1);
   localparam logic [HW-1:0] HIC_LAST = HW'(HICCUP_TICKS - 1);
   localparam logic [OW-1:0] OVL_LIM = OW'(OVL_TICKS);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_PERIOD - 1);

   logic rst_meta_reg;
   logic rst_n_reg;
   logic [BPS_FLAG_W-1:0] flags_raw;
   logic [BPS_FLAG_W-1:0] flags_s;
   bps_state_t state_reg;
   bps_state_t state_next;
   logic fsp_d_reg;
   logic [DW-1:0] div_reg;
   logic [HW-1:0] hic_cnt_reg;
   logic [OW-1:0] ovl_cnt_reg;
   logic therm_hold_reg;
   logic guard_block_reg;
   logic skip_reg;
   logic sink_off_reg;
   logic hs_on_reg;
   logic ls_on_reg;
   logic pg_pd_reg;
   logic pg_o_reg;
   logic ss_dis_reg;
   logic ref_ss_reg;
   logic lowp_reg;
   logic hic_reg;

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   assign flags_raw = {frequency_set_pin, ext_clk_mode, ls_reverse,
                       ss_at_ground, ss_above_1p4, ss_below_ref,
                       fb_out_window, fb_in_window, overload,
                       ls_sink_limit, ls_source_limit, peak_trip,
                       overshoot_guard, gd_supply_low, therm_release,
                       therm_trip, undervoltage_lockout, en_above_thr};

   // RULE_20 flag synchronisers
   bps_sync #(
      .WIDTH(BPS_FLAG_W),
      .STAGES(BPS_SYNC_STAGES)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n_reg),
      .async_in(flags_raw),
      .sync_out(flags_s)
   );

   wire en_s = flags_s[BPS_F_EN];
   wire uvlock_s = flags_s[BPS_F_UVLOCK];
   wire ttrip_s = flags_s[BPS_F_TTRIP];
   wire trel_s = flags_s[BPS_F_TREL];
   wire gdlow_s = flags_s[BPS_F_GDLOW];
   wire guard_s = flags_s[BPS_F_GUARD];
   wire peak_s = flags_s[BPS_F_PEAK];
   wire lssrc_s = flags_s[BPS_F_LSSRC];
   wire lssink_s = flags_s[BPS_F_LSSINK];
   wire ovl_s = flags_s[BPS_F_OVL];
   wire fbwin_s = flags_s[BPS_F_FBWIN];
   wire fbout_s = flags_s[BPS_F_FBOUT];
   wire ssref_s = flags_s[BPS_F_SSREF];
   wire ss14_s = flags_s[BPS_F_SS14];
   wire ssgnd_s = flags_s[BPS_F_SSGND];
   wire lsrev_s = flags_s[BPS_F_LSREV];
   wire extclk_s = flags_s[BPS_F_EXTCLK];
   wire fsp_s = flags_s[BPS_F_FSP];

   // RULE_19 cycle start on external falling edge
   wire ext_fall = extclk_s & fsp_d_reg & ~fsp_s;
   wire int_tick = ~extclk_s & (div_reg == DIV_LAST);
   wire tick = ext_fall | int_tick;
   wire [DW-1:0] div_next = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;

   // RULE_02 shutdown causes
   wire shutdown = uvlock_s | ~en_s | ttrip_s;
   wire run = (state_reg == BPS_ST_RUN);
   wire in_hic = (state_reg == BPS_ST_HICCUP);
   wire hic_done = in_hic & tick & (hic_cnt_reg == HIC_LAST);
   // RULE_15 more than the wait count of overloaded ticks
   wire ovl_trip = run & tick & ovl_s & (ovl_cnt_reg == OVL_LIM);
   // RULE_17 thermal hiccup may start after release
   wire therm_go = therm_hold_reg & trel_s & ~shutdown;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         BPS_ST_OFF:
         begin
            if (therm_go)
               state_next = BPS_ST_HICCUP;
            else if (!shutdown && !therm_hold_reg)
               state_next = BPS_ST_DISCH;
         end
         BPS_ST_DISCH:
         begin
            // RULE_03 wait for soft start at ground
            if (shutdown)
               state_next = BPS_ST_OFF;
            else if (ssgnd_s)
               state_next = BPS_ST_RUN;
         end
         BPS_ST_RUN:
         begin
            // RULE_16 over temperature leaves run
            if (shutdown)
               state_next = BPS_ST_OFF;
            else if (ovl_trip)
               state_next = BPS_ST_HICCUP;
         end
         BPS_ST_HICCUP:
         begin
            if (shutdown)
               state_next = BPS_ST_OFF;
            else if (hic_done)
               state_next = BPS_ST_DISCH;
         end
      endcase
   end

   wire [HW-1:0] hic_next = !in_hic ? '0 :
                            tick ? hic_cnt_reg + 1'b1 : hic_cnt_reg;
   wire [OW-1:0] ovl_next = (!run || !ovl_s) ? '0 :
                            (tick && ovl_cnt_reg != OVL_LIM) ?
                            ovl_cnt_reg + 1'b1 : ovl_cnt_reg;
   // trip sets, hiccup end clears; set wins
   wire therm_hold_next = ttrip_s | (therm_hold_reg & ~hic_done);

   // RULE_10 overshoot blocks until next tick
   wire guard_block_next = run & (guard_s | (guard_block_reg & ~tick));
   // RULE_12 sample sourcing limit at cycle boundary
   wire skip_next = run & (tick ? lssrc_s : skip_reg);
   // RULE_14 sinking limit latched for rest of cycle
   wire sink_off_next = run & (lssink_s | (sink_off_reg & ~tick));

   // RULE_02 RULE_15 no switching once leaving run
   wire sw_en = run & ~shutdown & ~ovl_trip;
   // RULE_08 RULE_09 RULE_11 high-side turn-off causes
   wire hs_cut = peak_s | guard_s | gdlow_s;
   // RULE_07 RULE_13 pulse starts at tick unless skipped, else holds
   wire hs_hold = hs_on_reg & ~guard_block_reg & ~skip_reg;
   wire hs_next = sw_en & ~hs_cut & (tick ? ~lssrc_s : hs_hold);
   // RULE_18 no reverse current while ss below 1.4 V
   wire prebias_cut = lsrev_s & ~ss14_s;
   wire ls_cut = lssink_s | (sink_off_reg & ~tick) | prebias_cut;
   // RULE_08 RULE_12 low side fills rest of cycle
   wire ls_next = sw_en & ~hs_next & ~ls_cut;

   // RULE_06 forced pull-down causes
   wire pg_bad = shutdown | ~ss14_s | therm_hold_reg | ~run;
   // RULE_04 RULE_05 hysteretic window
   wire pg_ok_now = ~pg_pd_reg;
   wire pg_ok_next = ~pg_bad & ~fbout_s & (pg_ok_now | fbwin_s);

   always_ff @(posedge sys_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg <= BPS_ST_OFF;
         fsp_d_reg <= 1'b0;
         div_reg <= '0;
         hic_cnt_reg <= '0;
         ovl_cnt_reg <= '0;
         therm_hold_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         fsp_d_reg <= fsp_s;
         div_reg <= div_next;
         hic_cnt_reg <= hic_next;
         ovl_cnt_reg <= ovl_next;
         therm_hold_reg <= therm_hold_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         guard_block_reg <= 1'b0;
         skip_reg <= 1'b0;
         sink_off_reg <= 1'b0;
         hs_on_reg <= 1'b0;
         ls_on_reg <= 1'b0;
      end
      else
      begin
         guard_block_reg <= guard_block_next;
         skip_reg <= skip_next;
         sink_off_reg <= sink_off_next;
         hs_on_reg <= hs_next;
         ls_on_reg <= ls_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         pg_pd_reg <= BPS_PG_PD_RST;
         pg_o_reg <= 1'b0;
         ss_dis_reg <= 1'b0;
         ref_ss_reg <= 1'b1;
         lowp_reg <= BPS_LOWP_RST;
         hic_reg <= 1'b0;
      end
      else
      begin
         pg_pd_reg <= ~pg_ok_next;
         pg_o_reg <= 1'b0;
         // RULE_03 discharge while waiting to restart
         ss_dis_reg <= (state_next == BPS_ST_DISCH);
         // RULE_01 lower of soft start and reference
         ref_ss_reg <= ssref_s;
         // RULE_02 low-current state
         lowp_reg <= (state_next == BPS_ST_OFF);
         hic_reg <= (state_next == BPS_ST_HICCUP);
      end
   end

   assign hs_on = hs_on_reg;
   assign ls_on = ls_on_reg;
   assign power_good_out_o = pg_o_reg;
   assign power_good_out_oe = pg_pd_reg;
   assign ss_discharge = ss_dis_reg;
   assign ref_from_ss = ref_ss_reg;
   assign low_power = lowp_reg;
   assign hiccup_active = hic_reg;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n_reg);

   sequence seq_hic_end;
      in_hic && hic_done && !shutdown;
   endsequence

   sequence seq_restart;
      (state_reg == BPS_ST_DISCH) && ss_discharge;
   endsequence

   chk_ref_select: assert property (ssref_s |=> ref_from_ss) // RULE_01
      else $error("reference select does not follow soft start");
   chk_shutdown_off: assert property ( // RULE_02
      shutdown |=> !hs_on && !ls_on && low_power)
      else $error("switching during shutdown");
   chk_run_via_disch: assert property ( // RULE_03
      (state_reg == BPS_ST_RUN) && !$past(run) |->
      $past(state_reg) == BPS_ST_DISCH && $past(ssgnd_s))
      else $error("run entered without discharge");
   chk_pg_window: assert property ( // RULE_05
      fbout_s |=> power_good_out_oe)
      else $error("power good released outside window");
   chk_pg_ss_low: assert property ( // RULE_06
      !ss14_s || shutdown |=> power_good_out_oe)
      else $error("power good released on fault");
   chk_gd_recharge: assert property ( // RULE_08
      run && gdlow_s && !shutdown && !ls_cut |=> !hs_on && ls_on)
      else $error("boot recharge not forced");
   chk_guard_hold: assert property ( // RULE_10
      guard_s ##1 !tick [*2] |-> !hs_on)
      else $error("high side on before next cycle");
   chk_peak_off: assert property ((peak_s || guard_s) |=> !hs_on) // RULE_11
      else $error("high side stays on after trip");
   chk_src_skip: assert property ( // RULE_12
      run && tick && lssrc_s |=> !hs_on)
      else $error("pulse not skipped on sourcing limit");
   chk_no_overlap: assert property (!(hs_on && ls_on)) // RULE_14
      else $error("both switches on");
   chk_prebias_ls: assert property ( // RULE_18
      lsrev_s && !ss14_s |=> !ls_on)
      else $error("low side sinks during pre-bias start");
   chk_ovl_hiccup: assert property ( // RULE_15
      ovl_trip && !shutdown |=> hiccup_active ##0 in_hic)
      else $error("overload did not start hiccup");
   chk_hic_restart: assert property ( // RULE_17
      seq_hic_end |=> seq_restart)
      else $error("hiccup end did not restart");

endmodule

//--- dv/bps_plant_model.sv
// Purpose: behavioural far side: soft start capacitor and external clock
// Assumes: soft start level moves one step per sys_clk
// Notes: external clock stands still high outside its mode
`timescale 1ns/1ps
module bps_plant_model
#(
   parameter int SS_START = 10,
   parameter int SS_TOP = 40
)
(
   input wire logic sys_clk,
   input wire logic ss_discharge,
   input wire logic low_power,
   input wire logic ext_clk_mode,
   output logic ss_below_ref,
   output logic ss_above_1p4,
   output logic ss_at_ground,
   output logic frequency_set_pin
);
   int ss_lvl = SS_START;
   logic [2:0] phase_reg = 3'h0;
   assign ss_at_ground = (ss_lvl == 0);
   assign ss_below_ref = (ss_lvl < 12);
   assign ss_above_1p4 = (ss_lvl > 28);
   always @(posedge sys_clk)
   begin
      if (ss_discharge && ss_lvl > 0)
         ss_lvl <= ss_lvl - 1;
      else if (!ss_discharge && !low_power && ss_lvl < SS_TOP)
         ss_lvl <= ss_lvl + 1;
   end
   always @(negedge sys_clk)
   begin
      phase_reg <= phase_reg + 3'h1;
      frequency_set_pin <= ext_clk_mode ? phase_reg[2] : 1'b1;
   end
endmodule

//--- dv/buck_protection_sequencer_tb_top.sv
// Purpose: self-checking bench for the protection sequencer
// Assumes: short hiccup, overload and tick counts
// Notes: expected levels queued by the driver, taken by the monitor
`timescale 1ns/1ps
module buck_protection_sequencer_tb_top;
   localparam int TP = 4;
   localparam int LIM = 300;
   localparam int HS = 0, LS = 1, PG = 2, DIS = 3, LP = 4, HIC = 5, REF = 6;
   localparam int PGO = 7;
   logic sys_clk = 1'b0, nrst = 1'b0, en = 1'b0, uv_lock = 1'b0;
   logic t_trip = 1'b0, t_rel = 1'b0, gd_low = 1'b0, ov_grd = 1'b0;
   logic peak = 1'b0, src_lim = 1'b0, sink_lim = 1'b0, ovl = 1'b0;
   logic fb_in = 1'b0, fb_out = 1'b0, ext_m = 1'b0, rev = 1'b0;
   wire logic hs_on, ls_on, pg_o, pg_oe, ss_dis, ref_ss, low_pwr, hic;
   wire logic ss_blw, ss_14, ss_gnd, fsp;
   wire logic [7:0] obs = {pg_o, ref_ss, hic, low_pwr, ss_dis, pg_oe, ls_on,
                           hs_on};
   int exp_sel[$];
   logic exp_val[$];
   int bad_count = 0, checks_done = 0, wait_cnt = 0;
   int seed = 32'h68996dfb;

   bps_sequencer #(.HICCUP_TICKS(8), .OVL_TICKS(4), .TICK_PERIOD(TP)) i_dut
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .en_above_thr(en),
      .undervoltage_lockout(uv_lock),
      .therm_trip(t_trip),
      .therm_release(t_rel),
      .gd_supply_low(gd_low),
      .overshoot_guard(ov_grd),
      .peak_trip(peak),
      .ls_source_limit(src_lim),
      .ls_sink_limit(sink_lim),
      .overload(ovl),
      .fb_in_window(fb_in),
      .fb_out_window(fb_out),
      .ss_below_ref(ss_blw),
      .ss_above_1p4(ss_14),
      .ss_at_ground(ss_gnd),
      .ls_reverse(rev),
      .ext_clk_mode(ext_m),
      .frequency_set_pin(fsp),
      .hs_on(hs_on),
      .ls_on(ls_on),
      .power_good_out_o(pg_o),
      .power_good_out_oe(pg_oe),
      .ss_discharge(ss_dis),
      .ref_from_ss(ref_ss),
      .low_power(low_pwr),
      .hiccup_active(hic)
   );

   bps_plant_model i_plant
   (
      .sys_clk(sys_clk),
      .ss_discharge(ss_dis),
      .low_power(low_pwr),
      .ext_clk_mode(ext_m),
      .ss_below_ref(ss_blw),
      .ss_above_1p4(ss_14),
      .ss_at_ground(ss_gnd),
      .frequency_set_pin(fsp)
   );

   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic expect_out(input int sel, input logic val);
      int n;
      exp_sel.push_back(sel);
      exp_val.push_back(val);
      for (n = 0; n < 2 * LIM && exp_sel.size() > 0; n++)
         @(negedge sys_clk);
      if (exp_sel.size() > 0)
      begin
         $display("BAD %0t expectation queue stuck", $time);
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic idle(input int n);
      int r;
      r = $random(seed);
      rev = r[0];
      repeat (n + (r[6:4])) @(negedge sys_clk);
   endtask

   always @(negedge sys_clk)
   begin
      if (exp_sel.size() > 0)
      begin
         if (obs[exp_sel[0]] === exp_val[0])
         begin
            checks_done++;
            wait_cnt = 0;
            void'(exp_sel.pop_front());
            void'(exp_val.pop_front());
         end
         else if (wait_cnt >= LIM)
         begin
            $display("BAD %0t output %0d never %b", $time, exp_sel[0],
               exp_val[0]);
            bad_count++;
            checks_done++;
            wrap_up();
         end
         else
            wait_cnt++;
      end
   end

   initial
   begin
      repeat (20) @(negedge sys_clk);
      expect_out(LP, 1'b1);
      expect_out(PG, 1'b1);
      expect_out(REF, 1'b1);
      nrst = 1'b1;
      $display("test reset done");
      idle(4);
      en = 1'b1;
      expect_out(DIS, 1'b1);
      expect_out(LP, 1'b0);
      expect_out(DIS, 1'b0);
      expect_out(HS, 1'b1);
      expect_out(REF, 1'b0);
      fb_in = 1'b1;
      expect_out(PG, 1'b0);
      expect_out(PGO, 1'b0);
      $display("test start done");
      idle(2);
      peak = 1'b1;
      expect_out(HS, 1'b0);
      expect_out(LS, 1'b1);
      peak = 1'b0;
      expect_out(HS, 1'b1);
      idle(2);
      ov_grd = 1'b1;
      expect_out(HS, 1'b0);
      ov_grd = 1'b0;
      expect_out(HS, 1'b1);
      idle(2);
      gd_low = 1'b1;
      expect_out(HS, 1'b0);
      expect_out(LS, 1'b1);
      gd_low = 1'b0;
      expect_out(HS, 1'b1);
      $display("test switch cut done");
      idle(2);
      peak = 1'b1;
      src_lim = 1'b1;
      expect_out(LS, 1'b1);
      peak = 1'b0;
      repeat (4 * TP) @(negedge sys_clk);
      expect_out(HS, 1'b0);
      src_lim = 1'b0;
      expect_out(HS, 1'b1);
      peak = 1'b1;
      expect_out(LS, 1'b1);
      sink_lim = 1'b1;
      expect_out(LS, 1'b0);
      expect_out(HS, 1'b0);
      sink_lim = 1'b0;
      peak = 1'b0;
      expect_out(HS, 1'b1);
      $display("test current limit done");
      idle(2);
      fb_out = 1'b1;
      expect_out(PG, 1'b1);
      fb_out = 1'b0;
      expect_out(PG, 1'b0);
      ext_m = 1'b1;
      peak = 1'b1;
      expect_out(HS, 1'b0);
      peak = 1'b0;
      expect_out(HS, 1'b1);
      ext_m = 1'b0;
      $display("test power good and clock done");
      idle(2);
      ovl = 1'b1;
      expect_out(HIC, 1'b1);
      expect_out(HS, 1'b0);
      ovl = 1'b0;
      expect_out(HIC, 1'b0);
      expect_out(DIS, 1'b1);
      expect_out(HS, 1'b1);
      $display("test overload done");
      idle(2);
      t_trip = 1'b1;
      expect_out(LP, 1'b1);
      expect_out(HS, 1'b0);
      expect_out(PG, 1'b1);
      t_trip = 1'b0;
      t_rel = 1'b1;
      expect_out(HIC, 1'b1);
      expect_out(DIS, 1'b1);
      expect_out(HS, 1'b1);
      $display("test thermal done");
      idle(2);
      rev = 1'b1;
      uv_lock = 1'b1;
      expect_out(LP, 1'b1);
      expect_out(PG, 1'b1);
      uv_lock = 1'b0;
      expect_out(HS, 1'b1);
      en = 1'b0;
      expect_out(LP, 1'b1);
      expect_out(HS, 1'b0);
      $display("test shutdown done");
      wrap_up();
   end
endmodule
